/* src/io_channel_chain_control.sv */
// Channel program sequencer: command fetch, chaining, branching, skipping and relocation.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "chain_ctrl_defs.svh"
module io_channel_chain_control #(
	parameter logic [23:0] RELOC_BASE = 24'h000100
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register bus.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Main storage.
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [3:0] mem_be_o,
	output logic [23:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic mem_err_i,
	input wire logic [31:0] mem_rdata_i,
	// Peripheral interface.
	output logic sel_o,
	output logic [7:0] cmd_o,
	input wire logic svc_in_i,
	input wire logic status_in_i,
	input wire logic [7:0] dev_status_i,
	input wire logic [7:0] bus_in_i,
	output logic [7:0] bus_out_o,
	output logic svc_out_o,
	output logic cmd_out_o,
	output logic stat_ack_o
);
	// ==========================================
	// State.
	chain_ctrl_pkg::chain_state_t st_r;
	chain_ctrl_pkg::chain_state_t st_nxt;
	logic fin;
	logic fil;
	logic fpc;
	logic fccc;
	logic fimm;
	logic [7:0] fstat;
	logic chain_go;
	logic chain_dat;
	logic acc;
	logic is_in;
	logic bdone;
	logic [23:0] nxt_ccw;
	logic [3:0] rkey;
	logic [7:0] rbyte;

	function automatic logic [23:0] rel_addr(input logic [3:0] k);
		rel_addr = RELOC_BASE + {18'h00000, k, 2'h0};
	endfunction : rel_addr

	// ==========================================
	// Next state.
	always_comb begin
		st_nxt = st_r;
		fin = 1'b0;
		fil = 1'b0;
		fpc = 1'b0;
		fccc = 1'b0;
		fimm = 1'b0;
		fstat = 8'h00;
		chain_go = 1'b0;
		chain_dat = 1'b0;
		st_nxt.sel = 1'b0;
		st_nxt.svc_out = 1'b0;
		st_nxt.cmd_out = 1'b0;
		st_nxt.stat_ack = 1'b0;
		nxt_ccw = st_r.cca + `CCW_STEP;
		rkey = st_r.hz ? 4'h0 : st_r.okey;
		is_in = (st_r.hcmd[1:0] == 2'h2) || (st_r.hcmd[3:0] == 4'h4) || (st_r.hcmd[3:0] == 4'hC);
		bdone = ~st_r.mem_req | mem_ack_i;
		case (st_r.haddr[1:0])
			2'h0: rbyte = mem_rdata_i[31:24];
			2'h1: rbyte = mem_rdata_i[23:16];
			2'h2: rbyte = mem_rdata_i[15:8];
			default: rbyte = mem_rdata_i[7:0];
		endcase
		// Register bus slave: one wait cycle, then the answer.
		acc = psel_i & penable_i & st_r.pready;
		st_nxt.pready = psel_i & penable_i & ~st_r.pready;
		st_nxt.pslverr = 1'b0;
		if (psel_i & penable_i & ~st_r.pready) begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata = `RST_WORD;
			case (paddr_i)
				`REG_CTRL: st_nxt.prdata = {30'h00000000, st_r.mode_sel, 1'b0};
				`REG_CAW: st_nxt.prdata = st_r.channel_address_word;
				`REG_STAT: st_nxt.prdata = {23'h000000, st_r.initial_status_word, 2'h0, st_r.ccode, 2'h0, st_r.done, st_r.busy};
				`REG_SW0: st_nxt.prdata = st_r.sw0;
				`REG_SW1: st_nxt.prdata = st_r.sw1;
				`REG_HCCW0: st_nxt.prdata = {st_r.hcmd, st_r.haddr};
				`REG_HCCW1: st_nxt.prdata = {st_r.hcd, st_r.hcc, st_r.hsli, st_r.hsk, 4'h0, st_r.hz, 7'h00, st_r.hcnt};
				`REG_HELD_ADDRESS_WORD: st_nxt.prdata = {8'h00, st_r.cca};
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		if (acc & pwrite_i) begin
			case (paddr_i)
				`REG_CAW: begin
					if (!st_r.busy) begin
						st_nxt.channel_address_word = pwdata_i;
					end
				end
				`REG_STAT: begin
					if (pwdata_i[`STAT_DONE]) begin
						st_nxt.done = 1'b0;
					end
				end
				`REG_CTRL: begin
					if (!st_r.busy) begin
						st_nxt.mode_sel = pwdata_i[`CTRL_SEL];
					end
					if (!st_r.busy && pwdata_i[`CTRL_START]) begin
						st_nxt.busy = 1'b1;
						st_nxt.okey = st_r.channel_address_word[`CAW_KEY_HI:`CAW_KEY_LO];
						st_nxt.hz = st_r.channel_address_word[`CAW_Z];
						st_nxt.pend = st_r.channel_address_word[23:0];
						st_nxt.first = 1'b1;
						st_nxt.dchain = 1'b0;
						st_nxt.ticprev = 1'b0;
						st_nxt.spc = 1'b0;
						st_nxt.sccc = 1'b0;
						st_nxt.rsrc = chain_ctrl_pkg::RU_CAW;
						st_nxt.st = chain_ctrl_pkg::S_RELOC;
						st_nxt.mem_req = 1'b1;
						st_nxt.mem_we = 1'b0;
						st_nxt.mem_addr = rel_addr(st_r.channel_address_word[`CAW_Z] ? 4'h0 : st_r.channel_address_word[`CAW_KEY_HI:`CAW_KEY_LO]);
					end
				end
				default: begin
				end
			endcase
		end
		// Channel program sequencing.
		case (st_r.st)
			chain_ctrl_pkg::S_IDLE: begin
			end
			chain_ctrl_pkg::S_RELOC: begin
				if (mem_ack_i) begin
					st_nxt.mem_req = 1'b0;
					if (mem_err_i) begin
						fin = 1'b1;
						fccc = 1'b1;
					end else begin
						st_nxt.reloc = mem_rdata_i[23:0];
						if (st_r.rsrc == chain_ctrl_pkg::RU_DATA) begin
							st_nxt.st = chain_ctrl_pkg::S_LOAD;
						end else begin
							st_nxt.cca = st_r.pend + mem_rdata_i[23:0];
							st_nxt.mem_req = 1'b1;
							st_nxt.mem_addr = st_r.pend + mem_rdata_i[23:0];
							st_nxt.st = chain_ctrl_pkg::S_CCW0;
						end
					end
				end
			end
			chain_ctrl_pkg::S_CCW0: begin
				if (mem_ack_i) begin
					st_nxt.mem_req = 1'b0;
					st_nxt.cw0 = mem_rdata_i;
					if (mem_err_i) begin
						st_nxt.sccc = st_r.dchain;
						st_nxt.st = chain_ctrl_pkg::S_TERM;
						st_nxt.terr = 1'b1;
						st_nxt.svcs = 1'b0;
						st_nxt.ilp = 1'b0;
						fin = ~st_r.dchain;
						fccc = 1'b1;
					end else if (mem_rdata_i[27:24] == `TIC_CODE) begin
						if (st_r.first || st_r.ticprev) begin
							fin = 1'b1;
							fpc = 1'b1;
							fimm = st_r.first;
						end else begin
							st_nxt.ticprev = 1'b1;
							st_nxt.pend = mem_rdata_i[23:0];
							st_nxt.rsrc = chain_ctrl_pkg::RU_TIC;
							if (st_r.hz && mem_rdata_i[`TIC_K + 24]) begin
								st_nxt.hz = 1'b0;
								st_nxt.mem_req = 1'b1;
								st_nxt.mem_addr = rel_addr(st_r.okey);
								st_nxt.st = chain_ctrl_pkg::S_RELOC;
							end else if (st_r.mode_sel) begin
								st_nxt.cca = mem_rdata_i[23:0] + st_r.reloc;
								st_nxt.mem_req = 1'b1;
								st_nxt.mem_addr = mem_rdata_i[23:0] + st_r.reloc;
							end else begin
								st_nxt.mem_req = 1'b1;
								st_nxt.mem_addr = rel_addr(rkey);
								st_nxt.st = chain_ctrl_pkg::S_RELOC;
							end
						end
					end else begin
						st_nxt.ticprev = 1'b0;
						st_nxt.mem_req = 1'b1;
						st_nxt.mem_addr = st_r.cca + `CCW_W1;
						st_nxt.st = chain_ctrl_pkg::S_CCW1;
					end
				end
			end
			chain_ctrl_pkg::S_CCW1: begin
				if (mem_ack_i) begin
					st_nxt.mem_req = 1'b0;
					st_nxt.cw1 = mem_rdata_i;
					if (mem_err_i || (mem_rdata_i[15:0] == 16'h0000)) begin
						st_nxt.sccc = st_r.dchain & mem_err_i;
						st_nxt.spc = st_r.dchain & ~mem_err_i;
						st_nxt.st = chain_ctrl_pkg::S_TERM;
						st_nxt.terr = 1'b1;
						st_nxt.svcs = 1'b0;
						st_nxt.ilp = 1'b0;
						fin = ~st_r.dchain;
						fccc = mem_err_i;
						fpc = ~mem_err_i;
					end else if (st_r.first || st_r.mode_sel) begin
						st_nxt.st = chain_ctrl_pkg::S_LOAD;
					end else begin
						st_nxt.rsrc = chain_ctrl_pkg::RU_DATA;
						st_nxt.mem_req = 1'b1;
						st_nxt.mem_addr = rel_addr(rkey);
						st_nxt.st = chain_ctrl_pkg::S_RELOC;
					end
				end
			end
			chain_ctrl_pkg::S_LOAD: begin
				st_nxt.haddr = st_r.cw0[23:0] + st_r.reloc;
				if (!st_r.dchain) begin
					st_nxt.hcmd = st_r.cw0[31:24];
				end
				st_nxt.hcd = st_r.cw1[`CCW_CD];
				st_nxt.hcc = st_r.cw1[`CCW_CC];
				st_nxt.hsli = st_r.cw1[`CCW_SLI];
				st_nxt.hsk = st_r.cw1[`CCW_SK];
				st_nxt.hcnt = st_r.cw1[15:0];
				st_nxt.nodata = st_r.dchain;
				st_nxt.ilp = 1'b0;
				st_nxt.terr = 1'b0;
				if (st_r.dchain) begin
					st_nxt.st = chain_ctrl_pkg::S_XFER;
				end else begin
					st_nxt.sel = 1'b1;
					st_nxt.st = chain_ctrl_pkg::S_ISS;
				end
			end
			chain_ctrl_pkg::S_ISS: begin
				if (status_in_i) begin
					st_nxt.stat_ack = 1'b1;
					fstat = dev_status_i;
					if ((st_r.hcmd[1:0] == 2'h3) && dev_status_i[`DS_CE]) begin
						if (!st_r.hcd && st_r.hcc) begin
							chain_go = dev_status_i[`DS_DE];
							st_nxt.st = chain_ctrl_pkg::S_CHAIN;
						end else begin
							fin = 1'b1;
							fimm = 1'b1;
						end
					end else if (dev_status_i == 8'h00) begin
						st_nxt.st = chain_ctrl_pkg::S_XFER;
					end else begin
						fin = 1'b1;
					end
				end
			end
			chain_ctrl_pkg::S_XFER: begin
				if (status_in_i) begin
					st_nxt.stat_ack = 1'b1;
					fstat = dev_status_i;
					if (st_r.nodata) begin
						fin = 1'b1;
						fil = 1'b1;
					end else if (!st_r.hcd && st_r.hcc && st_r.hsli) begin
						chain_go = dev_status_i[`DS_DE];
						st_nxt.st = chain_ctrl_pkg::S_CHAIN;
					end else begin
						fin = 1'b1;
						fil = st_r.hcd | ~st_r.hsli;
					end
				end else if (svc_in_i) begin
					st_nxt.st = chain_ctrl_pkg::S_BYTE;
					st_nxt.mem_req = ~(is_in & st_r.hsk);
					st_nxt.mem_we = is_in;
					st_nxt.mem_addr = st_r.haddr;
					st_nxt.mem_be = 4'h8 >> st_r.haddr[1:0];
					st_nxt.mem_wdata = {4{bus_in_i}};
				end
			end
			chain_ctrl_pkg::S_BYTE: begin
				if (bdone) begin
					st_nxt.mem_req = 1'b0;
					if (st_r.mem_req && mem_err_i) begin
						st_nxt.sccc = 1'b1;
						st_nxt.st = chain_ctrl_pkg::S_TERM;
						st_nxt.terr = 1'b1;
						st_nxt.svcs = 1'b0;
					end else begin
						st_nxt.svc_out = 1'b1;
						st_nxt.nodata = 1'b0;
						if (!is_in) begin
							st_nxt.bus_out = rbyte;
						end
						st_nxt.hcnt = st_r.hcnt - 16'h0001;
						st_nxt.haddr = (st_r.hcmd[3:0] == 4'hC) ? st_r.haddr - 24'h000001 : st_r.haddr + 24'h000001;
						st_nxt.st = chain_ctrl_pkg::S_XFER;
						if (st_r.hcnt == 16'h0001) begin
							if (st_r.hcd) begin
								chain_go = 1'b1;
								chain_dat = 1'b1;
							end else if (st_r.hcc && st_r.hsli) begin
								st_nxt.st = chain_ctrl_pkg::S_CHAIN;
							end else begin
								st_nxt.st = chain_ctrl_pkg::S_TERM;
								st_nxt.ilp = ~st_r.hsli;
								st_nxt.svcs = 1'b0;
							end
						end
					end
				end
			end
			chain_ctrl_pkg::S_CHAIN: begin
				if (status_in_i) begin
					st_nxt.stat_ack = 1'b1;
					chain_go = dev_status_i[`DS_DE];
				end
			end
			chain_ctrl_pkg::S_TERM: begin
				if (svc_in_i) begin
					st_nxt.cmd_out = 1'b1;
					st_nxt.svcs = 1'b1;
				end
				if (status_in_i) begin
					st_nxt.stat_ack = 1'b1;
					fstat = dev_status_i;
					if (!st_r.terr && !st_r.svcs && !st_r.hcd && st_r.hcc) begin
						chain_go = dev_status_i[`DS_DE];
						st_nxt.st = chain_ctrl_pkg::S_CHAIN;
					end else begin
						fin = 1'b1;
						fil = st_r.ilp & st_r.svcs;
					end
				end
			end
			default: begin
				st_nxt.st = chain_ctrl_pkg::S_IDLE;
			end
		endcase
		if (chain_go) begin
			st_nxt.cca = nxt_ccw;
			st_nxt.mem_req = 1'b1;
			st_nxt.mem_we = 1'b0;
			st_nxt.mem_addr = nxt_ccw;
			st_nxt.first = 1'b0;
			st_nxt.dchain = chain_dat;
			st_nxt.ticprev = 1'b0;
			st_nxt.st = chain_ctrl_pkg::S_CCW0;
		end
		if (fin) begin
			st_nxt.st = chain_ctrl_pkg::S_IDLE;
			st_nxt.mem_req = 1'b0;
			st_nxt.busy = 1'b0;
			st_nxt.done = 1'b1;
			st_nxt.initial_status_word = st_r.first & fimm;
			st_nxt.ccode = (st_r.first & fimm) ? `CC_ISW : `CC_NONE;
			st_nxt.sw0 = {st_r.okey, 4'h0, nxt_ccw};
			st_nxt.sw1 = {fstat, 1'b0, fil, st_r.spc | fpc, 2'h0, st_r.sccc | fccc, 2'h0, st_r.hcnt};
		end
	end

	// ==========================================
	// State register.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.st <= chain_ctrl_pkg::S_IDLE;
			st_r.rsrc <= chain_ctrl_pkg::RU_CAW;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// Outputs.
	assign prdata_o = st_r.prdata;
	assign pready_o = st_r.pready;
	assign pslverr_o = st_r.pslverr;
	assign mem_req_o = st_r.mem_req;
	assign mem_we_o = st_r.mem_we;
	assign mem_be_o = st_r.mem_be;
	assign mem_addr_o = st_r.mem_addr;
	assign mem_wdata_o = st_r.mem_wdata;
	assign sel_o = st_r.sel;
	assign cmd_o = st_r.hcmd;
	assign bus_out_o = st_r.bus_out;
	assign svc_out_o = st_r.svc_out;
	assign cmd_out_o = st_r.cmd_out;
	assign stat_ack_o = st_r.stat_ack;
endmodule : io_channel_chain_control
`default_nettype wire

/* shared/chain_ctrl_defs.svh */
// Register offsets, field positions and fixed codes of the channel chain control block.
`ifndef CHAIN_CTRL_DEFS_SVH
`define CHAIN_CTRL_DEFS_SVH
// ==========================================
// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_CAW 8'h04
`define REG_STAT 8'h08
`define REG_SW0 8'h0C
`define REG_SW1 8'h10
`define REG_HCCW0 8'h14
`define REG_HCCW1 8'h18
`define REG_HELD_ADDRESS_WORD 8'h1C
// ==========================================
// Control and status register bits.
`define CTRL_START 0
`define CTRL_SEL 1
`define STAT_BUSY 0
`define STAT_DONE 1
// ==========================================
// Address word and command word fields.
`define CAW_KEY_HI 31
`define CAW_KEY_LO 28
`define CAW_Z 27
`define CCW_CD 31
`define CCW_CC 30
`define CCW_SLI 29
`define CCW_SK 28
`define HELD_COMMAND_WORD_Z 23
`define TIC_CODE 4'h8
`define TIC_K 4
// ==========================================
// Subchannel status bits within the status byte.
`define SUB_IL 6
`define SUB_PC 5
`define SUB_CCC 2
// ==========================================
// Device status bits and codes.
`define DS_CE 3
`define DS_DE 2
`define CC_ISW 2'h1
`define CC_NONE 2'h0
`define CCW_STEP 24'h000008
`define CCW_W1 24'h000004
`define RST_WORD 32'h00000000
`endif

/* shared/chain_ctrl_pkg.sv */
// Types of the channel chain control block.
package chain_ctrl_pkg;
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_RELOC = 10'h002,
		S_CCW0 = 10'h004,
		S_CCW1 = 10'h008,
		S_LOAD = 10'h010,
		S_ISS = 10'h020,
		S_XFER = 10'h040,
		S_BYTE = 10'h080,
		S_CHAIN = 10'h100,
		S_TERM = 10'h200
	} state_t;
	typedef enum logic [1:0] {
		RU_CAW = 2'h0,
		RU_DATA = 2'h1,
		RU_TIC = 2'h2
	} rel_use_t;
	typedef struct packed {
		state_t st;
		rel_use_t rsrc;
		logic mode_sel;
		logic [31:0] channel_address_word;
		logic [3:0] okey;
		logic [23:0] reloc;
		logic [23:0] pend;
		logic [23:0] cca;
		logic [31:0] cw0;
		logic [31:0] cw1;
		logic [7:0] hcmd;
		logic [23:0] haddr;
		logic hcd;
		logic hcc;
		logic hsli;
		logic hsk;
		logic hz;
		logic [15:0] hcnt;
		logic first;
		logic dchain;
		logic ticprev;
		logic nodata;
		logic ilp;
		logic svcs;
		logic terr;
		logic spc;
		logic sccc;
		logic busy;
		logic done;
		logic initial_status_word;
		logic [1:0] ccode;
		logic [31:0] sw0;
		logic [31:0] sw1;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic mem_req;
		logic mem_we;
		logic [3:0] mem_be;
		logic [23:0] mem_addr;
		logic [31:0] mem_wdata;
		logic sel;
		logic svc_out;
		logic cmd_out;
		logic stat_ack;
		logic [7:0] bus_out;
	} chain_state_t;
endpackage : chain_ctrl_pkg

/* dv/chain_ctrl_checker.sv */
// Port-level assertions of the channel chain control block.
`timescale 1ns/1ps
`default_nettype none
module chain_ctrl_checker (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register bus.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Main storage.
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [3:0] mem_be_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic mem_ack_i,
	// Peripheral interface.
	input wire logic sel_o,
	input wire logic [7:0] cmd_o,
	input wire logic svc_in_i,
	input wire logic status_in_i,
	input wire logic svc_out_o,
	input wire logic cmd_out_o,
	input wire logic stat_ack_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Handshake steps.
	sequence apb_wait;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence mem_pending;
		mem_req_o && !mem_ack_i;
	endsequence
	// ==========================================
	// Assertions.
	a_apb_one_wait: assert property (apb_wait |=> pready_o)
		else $error("APB answer late");
	a_pready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	a_slverr_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	a_mem_req_hold: assert property (mem_pending |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("storage request dropped early");
	a_write_one_lane: assert property (mem_req_o && mem_we_o |-> $onehot(mem_be_o))
		else $error("data write not a single byte");
	a_cmd_out_cause: assert property (cmd_out_o |-> $past(svc_in_i))
		else $error("command out without service in");
	a_stat_ack_cause: assert property (stat_ack_o |-> $past(status_in_i))
		else $error("status ack without status");
	a_cmd_needs_sel: assert property ($changed(cmd_o) |-> ##[0:1] sel_o)
		else $error("command changed without selection");
	a_svc_out_pulse: assert property (svc_out_o |=> !svc_out_o)
		else $error("service out longer than one cycle");
endmodule : chain_ctrl_checker
bind io_channel_chain_control chain_ctrl_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
	.mem_we_o(mem_we_o), .mem_be_o(mem_be_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
	.sel_o(sel_o), .cmd_o(cmd_o), .svc_in_i(svc_in_i), .status_in_i(status_in_i),
	.svc_out_o(svc_out_o), .cmd_out_o(cmd_out_o), .stat_ack_o(stat_ack_o));
`default_nettype wire

/* dv/periph_unit_model.sv */
// Peripheral control unit model on the channel's device interface.
`timescale 1ns/1ps
`default_nettype none
module periph_unit_model (
	// Clock.
	input wire logic mclk_i,
	// Channel side.
	input wire logic sel_i,
	input wire logic svc_out_i,
	input wire logic cmd_out_i,
	input wire logic stat_ack_i,
	output logic svc_in_o,
	output logic status_in_o,
	output logic [7:0] dev_status_o,
	output logic [7:0] bus_in_o,
	// Test control.
	input wire logic [7:0] nbytes_i,
	input wire logic [7:0] gap_i,
	output logic term_o
);
	int k;
	int n;
	logic got;
	logic stop;
	// Presents status for one cycle and retries until it is accepted, at most four presentations in all.
	task automatic present(input logic [7:0] s);
		got = 1'b0;
		for (int t = 0; t < 4 && !got; t++) begin
			status_in_o <= 1'b1;
			dev_status_o <= s;
			@(posedge mclk_i);
			status_in_o <= 1'b0;
			dev_status_o <= ~s;
			for (n = 0; n < 12 && !got; n++) begin
				@(posedge mclk_i);
				got = stat_ack_i;
			end
		end
	endtask : present
	initial begin
		svc_in_o = 1'b0;
		status_in_o = 1'b0;
		dev_status_o = 8'hFF;
		bus_in_o = 8'h5A;
		term_o = 1'b0;
		forever begin
			@(posedge mclk_i);
			if (sel_i === 1'b1) begin
				term_o <= 1'b0;
				repeat (gap_i) @(posedge mclk_i);
				present(8'h00);
				k = 0;
				stop = 1'b0;
				while (k < nbytes_i && !stop) begin
					repeat (gap_i) @(posedge mclk_i);
					svc_in_o <= 1'b1;
					bus_in_o <= 8'hA0 + 8'(k);
					@(posedge mclk_i);
					svc_in_o <= 1'b0;
					bus_in_o <= ~bus_in_o;
					got = 1'b0;
					for (n = 0; n < 20 && !got; n++) begin
						@(posedge mclk_i);
						if (svc_out_i === 1'b1) begin
							got = 1'b1;
							k++;
						end
						if (cmd_out_i === 1'b1) begin
							got = 1'b1;
							stop = 1'b1;
						end
					end
				end
				term_o <= stop;
				repeat (gap_i) @(posedge mclk_i);
				present(8'h0C);
			end
		end
	end
endmodule : periph_unit_model
`default_nettype wire

/* dv/io_channel_chain_control_tb_top.sv */
// Testbench of the channel chain control block.
`timescale 1ns/1ps
`default_nettype none
`include "chain_ctrl_defs.svh"
module io_channel_chain_control_tb_top;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h00000000;
	logic mem_ack_i = 1'b0;
	logic mem_err_i = 1'b0;
	logic [10:0] err_idx = 11'h7FF;
	logic [7:0] last_out = 8'h00;
	logic [31:0] mem_rdata_i = 32'h00000000;
	logic [31:0] prdata_o, mem_wdata_o, stat, sw1, v;
	logic pready_o, pslverr_o, mem_req_o, mem_we_o, sel_o, svc_out_o, cmd_out_o, stat_ack_o;
	logic svc_in, status_in, term, err;
	logic [3:0] mem_be_o;
	logic [23:0] mem_addr_o;
	logic [7:0] cmd_o, bus_out_o, dev_status, bus_in;
	logic [7:0] nbytes = 8'h00;
	logic [7:0] gap = 8'h01;
	logic [31:0] mem [0:2047];
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	io_channel_chain_control dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_be_o(mem_be_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
		.mem_err_i(mem_err_i), .mem_rdata_i(mem_rdata_i), .sel_o(sel_o), .cmd_o(cmd_o), .svc_in_i(svc_in),
		.status_in_i(status_in), .dev_status_i(dev_status), .bus_in_i(bus_in), .bus_out_o(bus_out_o),
		.svc_out_o(svc_out_o), .cmd_out_o(cmd_out_o), .stat_ack_o(stat_ack_o));
	periph_unit_model u_dev (.mclk_i(mclk_i), .sel_i(sel_o), .svc_out_i(svc_out_o), .cmd_out_i(cmd_out_o),
		.stat_ack_i(stat_ack_o), .svc_in_o(svc_in), .status_in_o(status_in), .dev_status_o(dev_status),
		.bus_in_o(bus_in), .nbytes_i(nbytes), .gap_i(gap), .term_o(term));
	// ==========================================
	// Clock, storage model and timeout.
	always #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		mem_ack_i <= mem_req_o && !mem_ack_i;
		mem_err_i <= mem_req_o && !mem_ack_i && (mem_addr_o[12:2] == err_idx);
		mem_rdata_i <= ~mem_rdata_i;
		if (svc_out_o) begin
			last_out <= bus_out_o;
		end
		if (mem_req_o && !mem_ack_i) begin
			mem_rdata_i <= mem[mem_addr_o[12:2]];
			for (int b = 0; b < 4; b++) begin
				if (mem_we_o && mem_be_o[b]) begin
					mem[mem_addr_o[12:2]][b*8+:8] <= mem_wdata_o[b*8+:8];
				end
			end
		end
	end
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ==========================================
	// Tasks.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask : wr
	task automatic run(input logic [31:0] w0, input logic [31:0] w1, input logic [7:0] nb);
		int n;
		mem[11'h480] = w0;
		mem[11'h481] = w1;
		nbytes <= nb;
		wr(`REG_CAW, 32'h20000200);
		wr(`REG_CTRL, 32'h00000001);
		n = 0;
		do begin
			apb(1'b0, `REG_STAT, 32'h0, stat);
			n++;
		end while (stat[`STAT_DONE] !== 1'b1 && n < 200);
		check(32'(stat[`STAT_DONE]), 32'h1);
		apb(1'b0, `REG_SW1, 32'h0, sw1);
		wr(`REG_STAT, 32'h00000002);
	endtask : run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================
	// Tests.
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i] = 32'h00000000;
		end
		mem[11'h042] = 32'h00001000;
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		apb(1'b0, `REG_STAT, 32'h0, stat);
		check(stat, 32'h00000000);
		apb(1'b0, 8'h20, 32'h0, v);
		check(v, 32'h00000000);
		check(32'(err), 32'h1);
		$display("test registers done");
		mem[11'h482] = 32'h00000400;
		mem[11'h483] = 32'h00000002;
		run(32'h02000300, 32'h80000002, 8'h04);
		check(32'(mem[11'h4C0][31:16]), 32'h0000A0A1);
		check(32'(mem[11'h500][31:16]), 32'h0000A2A3);
		check(32'(sw1[22]), 32'h0);
		check(32'(sw1[15:0]), 32'h0);
		apb(1'b0, `REG_HELD_ADDRESS_WORD, 32'h0, v);
		check(32'(v[23:0]), 32'h00001208);
		check(32'(cmd_o), 32'h02);
		run(32'h02000300, 32'h80000002, 8'h02);
		check(32'(sw1[22]), 32'h1);
		check(32'(sw1[15:0]), 32'h2);
		apb(1'b0, `REG_SW0, 32'h0, v);
		check(v, 32'h20001210);
		$display("test data chain done");
		gap <= 8'h05;
		for (int i = 0; i < 2; i++) begin
			run(32'h02000600, (i != 0) ? 32'h20000004 : 32'h00000004, 8'h01);
			check(32'(sw1[22]), 32'(i == 0));
			check(32'(sw1[15:0]), 32'h3);
		end
		$display("test early end done");
		gap <= 8'h01;
		mem[11'h482] = 32'h02000800;
		mem[11'h483] = 32'h00000000;
		run(32'h02000700, 32'h80000001, 8'h04);
		check(32'(sw1[21]), 32'h1);
		check(32'(term), 32'h1);
		$display("test zero count done");
		err_idx <= 11'h482;
		run(32'h02000700, 32'h80000001, 8'h04);
		check(32'(sw1[18]), 32'h1);
		check(32'(term), 32'h1);
		err_idx <= 11'h7FF;
		$display("test fetch error done");
		mem[11'h640] = 32'h12345678;
		run(32'h02000900, 32'h10000001, 8'h01);
		check(mem[11'h640], 32'h12345678);
		check(32'(sw1[22]), 32'h0);
		mem[11'h6C0] = 32'hC3000000;
		run(32'h01000B00, 32'h10000001, 8'h01);
		check(32'(last_out), 32'hC3);
		$display("test skip done");
		run(32'h08000200, 32'h00000000, 8'h00);
		check(32'(stat[8]), 32'h1);
		check(32'(sw1[21]), 32'h1);
		$display("test branch first done");
		tally_and_finish();
	end
endmodule : io_channel_chain_control_tb_top
`default_nettype wire
